// ### core/cio_pkg.sv
package cio_pkg;

    localparam int ACC_W = 4;
    localparam int WORD_W = 10;

    // Instruction codes
    localparam logic [9:0] OP_IN_K = 10'h26f;
    localparam logic [9:0] OP_IN_P0 = 10'h260;
    localparam logic [9:0] OP_IN_P1 = 10'h261;
    localparam logic [9:0] OP_IN_P2 = 10'h262;
    localparam logic [9:0] OP_IN_P3 = 10'h263;
    localparam logic [9:0] OP_OUT_K = 10'h21f;
    localparam logic [9:0] OP_OUT_P0 = 10'h220;
    localparam logic [9:0] OP_OUT_P1 = 10'h221;
    localparam logic [9:0] OP_OUT_P2 = 10'h222;
    localparam logic [9:0] OP_OUT_P3 = 10'h223;
    localparam logic [9:0] OP_OR = 10'h019;
    localparam logic [9:0] OP_PD_KEEP = 10'h002;
    localparam logic [9:0] OP_PD_FULL = 10'h008;
    localparam logic [9:0] OP_PD_ARM = 10'h05b;
    localparam logic [9:0] OP_ROT = 10'h01d;
    localparam logic [9:0] OP_LA_BASE = 10'h070;
    localparam logic [9:0] OP_LA_MASK = 10'h3f0;
    localparam logic [9:0] OP_RB_BASE = 10'h04c;
    localparam logic [9:0] OP_RB_MASK = 10'h3fc;
    localparam logic [9:0] OP_LXY_BASE = 10'h300;
    localparam logic [9:0] OP_LXY_MASK = 10'h300;

    // Reset values
    localparam logic [3:0] ACC_RST = 4'h0;
    localparam logic [3:0] PTR_RST = 4'h0;
    localparam logic [3:0] PORT_RST = 4'h0;

    typedef enum logic [2:0] {
        CIO_RUN = 3'b001,
        CIO_BACKUP_KEEP = 3'b010,
        CIO_BACKUP_FULL = 3'b100
    } cio_pwr_e;

    typedef struct packed {
        logic in_k;
        logic in_p0;
        logic in_p1;
        logic in_p2;
        logic in_p3;
        logic out_k;
        logic out_p0;
        logic out_p1;
        logic out_p2;
        logic out_p3;
        logic mem_or;
        logic pd_keep;
        logic pd_full;
        logic pd_arm;
        logic rot;
        logic la;
        logic rb;
        logic load_pointer_pair;
    } cio_dec_s;

    typedef struct packed {
        logic [3:0] p0;
        logic [3:0] p1;
        logic [1:0] p2;
        logic [1:0] p3;
        logic k;
    } cio_port_s;

endpackage

// ### core/cio_decode.sv
`timescale 1ns/10ps
module cio_decode (
    input wire logic [9:0] word,
    output cio_pkg::cio_dec_s dec
);
    // Exact and masked matches, one machine cycle each
    assign dec.in_k = (word == cio_pkg::OP_IN_K);
    assign dec.in_p0 = (word == cio_pkg::OP_IN_P0);
    assign dec.in_p1 = (word == cio_pkg::OP_IN_P1);
    assign dec.in_p2 = (word == cio_pkg::OP_IN_P2);
    assign dec.in_p3 = (word == cio_pkg::OP_IN_P3);
    assign dec.out_k = (word == cio_pkg::OP_OUT_K);
    assign dec.out_p0 = (word == cio_pkg::OP_OUT_P0);
    assign dec.out_p1 = (word == cio_pkg::OP_OUT_P1);
    assign dec.out_p2 = (word == cio_pkg::OP_OUT_P2);
    assign dec.out_p3 = (word == cio_pkg::OP_OUT_P3);
    assign dec.mem_or = (word == cio_pkg::OP_OR);
    assign dec.pd_keep = (word == cio_pkg::OP_PD_KEEP);
    assign dec.pd_full = (word == cio_pkg::OP_PD_FULL);
    assign dec.pd_arm = (word == cio_pkg::OP_PD_ARM);
    assign dec.rot = (word == cio_pkg::OP_ROT);
    assign dec.la = ((word & cio_pkg::OP_LA_MASK) == cio_pkg::OP_LA_BASE);
    assign dec.rb = ((word & cio_pkg::OP_RB_MASK) == cio_pkg::OP_RB_BASE);
    assign dec.load_pointer_pair = ((word & cio_pkg::OP_LXY_MASK) == cio_pkg::OP_LXY_BASE);
endmodule

// ### core/cio_sync.sv
`timescale 1ns/10ps
module cio_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // Two stages for pin levels from outside the clock domain
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ### core/cio_core.sv
`timescale 1ns/10ps
// Functional notes
// RL1: Port K input: bit0 gets pin, upper zeroed
// RL2: Four-bit port inputs load whole accumulator
// RL3: Two-bit port inputs fill bits 1:0
// RL4: Immediate load; consecutive repeats skipped
// RL5: Pointer pair load writes X and Y
// RL6: Consecutive pointer pair loads: first only
// RL7: Port K output takes accumulator bit0
// RL8: Four-bit port outputs take accumulator
// RL9: Two-bit port outputs take bits 1:0
// RL10: Memory OR into accumulator
// RL11: Keep-detector power-down needs arm first
// RL12: Keep-detector backup leaves detector running
// RL13: Unarmed power-down acts as no-operation
// RL14: Full-stop power-down needs arm first
// RL15: Full-stop backup halts detector too
// RL16: Rotate right through carry
// RL17: Clear addressed memory bit
// RL18: One word, one cycle; only rotate touches carry
module cio_core (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    input wire logic [3:0] mem_rdata,
    input wire cio_pkg::cio_port_s pin_in,
    input wire logic wake,
    output logic [3:0] acc,
    output logic carry_flag,
    output logic [3:0] ptr_x,
    output logic [3:0] ptr_y,
    output logic mem_we,
    output logic [3:0] mem_wdata,
    output cio_pkg::cio_port_s pin_out,
    output logic skipped,
    output logic backup,
    output logic detector_on,
    output logic clock_halt
);

    ////////////////////////////////////////////////////////////////////////
    // Input stage
    cio_pkg::cio_port_s pin_s;
    cio_pkg::cio_dec_s dec;

    cio_sync #(.W($bits(cio_pkg::cio_port_s))) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .async_in(pin_in),
        .sync_out(pin_s)
    );

    cio_decode u_dec (
        .word(instr_word),
        .dec(dec)
    );

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [3:0] acc_q, acc_d;
    logic cy_q, cy_d;
    logic [3:0] x_q, x_d;
    logic [3:0] y_q, y_d;
    logic prev_la_q, prev_lxy_q, prev_arm_q;
    logic we_q;
    logic [3:0] wdata_q;
    logic skip_q;
    logic backup_q, backup_d;
    logic det_q, det_d;
    logic halt_q, halt_d;
    cio_pkg::cio_port_s out_q, out_d;
    cio_pkg::cio_pwr_e pwr_q, pwr_d;

    // Instruction retires one per enabled cycle while running
    wire run = (pwr_q == cio_pkg::CIO_RUN);
    wire exec = ce && instr_valid && run; // see RL18
    wire la_skip = dec.la && prev_la_q; // see RL4
    wire lxy_skip = dec.load_pointer_pair && prev_lxy_q; // see RL6
    wire do_skip = la_skip || lxy_skip;
    // A skipped load still retires, so the run stays alive
    wire act = exec && !do_skip;

    ////////////////////////////////////////////////////////////////////////
    // Per-instruction strobes
    wire go_in_k = act && dec.in_k; // see RL1
    wire go_in_p0 = act && dec.in_p0; // see RL2
    wire go_in_p1 = act && dec.in_p1; // see RL2
    wire go_in_p2 = act && dec.in_p2; // see RL3
    wire go_in_p3 = act && dec.in_p3; // see RL3
    wire go_la = act && dec.la; // see RL4
    wire go_lxy = act && dec.load_pointer_pair; // see RL5, RL6
    wire go_out_k = act && dec.out_k; // see RL7
    wire go_out_p0 = act && dec.out_p0; // see RL8
    wire go_out_p1 = act && dec.out_p1; // see RL8
    wire go_out_p2 = act && dec.out_p2; // see RL9
    wire go_out_p3 = act && dec.out_p3; // see RL9
    wire go_or = act && dec.mem_or; // see RL10
    wire go_rot = act && dec.rot; // see RL16
    wire go_rb = act && dec.rb; // see RL17
    // Power-down valid only right after arm; otherwise a no-op
    wire pd_keep_go = act && dec.pd_keep && prev_arm_q; // see RL11, RL13
    wire pd_full_go = act && dec.pd_full && prev_arm_q; // see RL14, RL13
    wire wake_go = ce && !run && wake;

    ////////////////////////////////////////////////////////////////////////
    // Operand shaping
    wire [3:0] acc_pin_k = {3'h0, pin_s.k}; // see RL1
    wire [3:0] acc_pin_p2 = {2'h0, pin_s.p2}; // see RL3
    wire [3:0] acc_pin_p3 = {2'h0, pin_s.p3}; // see RL3
    wire [3:0] acc_or = acc_q | mem_rdata; // see RL10
    // Carry enters at the top, bit 0 falls out into carry
    wire [3:0] acc_rot = {cy_q, acc_q[3:1]}; // see RL16
    wire [3:0] imm_lo = instr_word[3:0];
    wire [3:0] imm_hi = instr_word[7:4];

    // Bit clear, one lane per nibble bit
    wire [1:0] rb_sel = instr_word[1:0];
    wire [3:0] rb_data;
    for (genvar i = 0; i < 4; i++) begin : g_rb
        assign rb_data[i] = mem_rdata[i] && (rb_sel != 2'(i)); // see RL17
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator and carry
    always_comb begin
        acc_d = acc_q;
        cy_d = cy_q;
        if (go_in_k) begin
            acc_d = acc_pin_k;
        end
        if (go_in_p0) begin
            acc_d = pin_s.p0;
        end
        if (go_in_p1) begin
            acc_d = pin_s.p1;
        end
        if (go_in_p2) begin
            acc_d = acc_pin_p2;
        end
        if (go_in_p3) begin
            acc_d = acc_pin_p3;
        end
        if (go_la) begin
            acc_d = imm_lo;
        end
        if (go_or) begin
            acc_d = acc_or;
        end
        // Only the rotate reaches the carry
        if (go_rot) begin
            acc_d = acc_rot;
            cy_d = acc_q[0]; // see RL16, RL18
        end
    end

    // Pointer pair
    always_comb begin
        x_d = x_q;
        y_d = y_q;
        if (go_lxy) begin
            x_d = imm_hi; // see RL5
            y_d = imm_lo; // see RL5
        end
    end

    // Port latches
    always_comb begin
        out_d = out_q;
        if (go_out_k) begin
            out_d.k = acc_q[0]; // see RL7
        end
        if (go_out_p0) begin
            out_d.p0 = acc_q; // see RL8
        end
        if (go_out_p1) begin
            out_d.p1 = acc_q; // see RL8
        end
        if (go_out_p2) begin
            out_d.p2 = acc_q[1:0]; // see RL9
        end
        if (go_out_p3) begin
            out_d.p3 = acc_q[1:0]; // see RL9
        end
    end

    // Power state
    always_comb begin
        pwr_d = pwr_q;
        if (pd_keep_go) begin
            pwr_d = cio_pkg::CIO_BACKUP_KEEP; // see RL11
        end
        if (pd_full_go) begin
            pwr_d = cio_pkg::CIO_BACKUP_FULL; // see RL14
        end
        // Wake returns to run; RAM and registers are retained
        if (wake_go) begin
            pwr_d = cio_pkg::CIO_RUN;
        end
    end

    // Status flags follow the next power state so they leave a flop
    assign backup_d = (pwr_d != cio_pkg::CIO_RUN);
    assign det_d = (pwr_d != cio_pkg::CIO_BACKUP_FULL); // see RL12, RL15
    assign halt_d = (pwr_d == cio_pkg::CIO_BACKUP_FULL); // see RL15

    ////////////////////////////////////////////////////////////////////////
    // Registers, one short block per group
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            acc_q <= cio_pkg::ACC_RST;
            cy_q <= 1'b0;
        end else if (ce) begin
            acc_q <= acc_d;
            cy_q <= cy_d;
        end
    end

    // Pointers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            x_q <= cio_pkg::PTR_RST;
            y_q <= cio_pkg::PTR_RST;
        end else if (ce) begin
            x_q <= x_d;
            y_q <= y_d;
        end
    end

    // Pins hold their level through backup
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            out_q.p0 <= cio_pkg::PORT_RST;
            out_q.p1 <= cio_pkg::PORT_RST;
            out_q.p2 <= cio_pkg::PORT_RST[1:0];
            out_q.p3 <= cio_pkg::PORT_RST[1:0];
            out_q.k <= cio_pkg::PORT_RST[0];
        end else if (ce) begin
            out_q <= out_d;
        end
    end

    // Power state and its status flags advance together
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pwr_q <= cio_pkg::CIO_RUN;
            backup_q <= 1'b0;
            det_q <= 1'b1;
            halt_q <= 1'b0;
        end else if (ce) begin
            pwr_q <= pwr_d;
            backup_q <= backup_d;
            det_q <= det_d;
            halt_q <= halt_d;
        end
    end

    // Run tracking: skipped loads still extend the run
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prev_la_q <= 1'b0;
            prev_lxy_q <= 1'b0;
            prev_arm_q <= 1'b0;
        end else if (exec) begin
            prev_la_q <= dec.la; // see RL4
            prev_lxy_q <= dec.load_pointer_pair; // see RL6
            prev_arm_q <= dec.pd_arm; // see RL11, RL14
        end
    end

    // Memory write strobe lasts one enabled cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            we_q <= 1'b0;
            wdata_q <= 4'h0;
        end else if (ce) begin
            we_q <= go_rb; // see RL17
            wdata_q <= rb_data;
        end
    end

    // Skip pulse marks the word just dropped
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            skip_q <= 1'b0;
        end else if (ce) begin
            skip_q <= exec && do_skip; // see RL4, RL6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign acc = acc_q;
    assign carry_flag = cy_q;
    assign ptr_x = x_q;
    assign ptr_y = y_q;
    assign mem_we = we_q;
    assign mem_wdata = wdata_q;
    assign pin_out = out_q;
    assign skipped = skip_q;
    assign backup = backup_q;
    // Keep variant leaves the detector alive; full stop kills it
    assign detector_on = det_q; // see RL12, RL15
    assign clock_halt = halt_q; // see RL15

endmodule

// ### verification/cio_pin_model.sv
`timescale 1ns/10ps
// Outside circuit on the port pins: levels change only on the clock, so the
// two-stage input synchroniser always sees a clean edge to follow
module cio_pin_model (
    input wire logic clk_sys,
    input wire logic [12:0] level,
    output cio_pkg::cio_port_s pin_in
);
    always_ff @(posedge clk_sys) begin
        pin_in <= level;
    end
endmodule

// ### verification/cio_core_sva.sv
`timescale 1ns/10ps
module cio_core_sva (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    input wire logic [3:0] mem_rdata,
    input wire logic [3:0] acc,
    input wire logic carry_flag,
    input wire cio_pkg::cio_port_s pin_out,
    input wire logic backup,
    input wire logic detector_on,
    input wire logic clock_halt
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    wire logic run = ce && instr_valid && !backup;
    ////////////////////////////////////////////////////////////////////////
    sequence s_op(logic [9:0] code);
        run && instr_word == code;
    endsequence
    sequence s_arm_then(logic [9:0] code);
        s_op(cio_pkg::OP_PD_ARM) ##1 s_op(code);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_in_single_zero:
    assert property (s_op(cio_pkg::OP_IN_K) |=> acc[3:1] == 3'h0) else $error("Upper bits set");
    a_in_two_bit:
    assert property (s_op(cio_pkg::OP_IN_P2) |=> acc[3:2] == 2'h0) else $error("Bits 3:2 set");
    a_out_single_bit:
    assert property (s_op(cio_pkg::OP_OUT_K) |=> pin_out.k == $past(acc[0]))
        else $error("Single port level wrong");
    a_out_port_word:
    assert property (s_op(cio_pkg::OP_OUT_P0) |=> pin_out.p0 == $past(acc))
        else $error("Port zero level wrong");
    a_out_two_bit:
    assert property (s_op(cio_pkg::OP_OUT_P3) |=> pin_out.p3 == $past(acc[1:0]))
        else $error("Port three level wrong");
    a_or_result:
    assert property (s_op(cio_pkg::OP_OR) |=> acc == ($past(acc) | $past(mem_rdata)))
        else $error("Memory OR result wrong");
    a_rotate_chain:
    assert property (s_op(cio_pkg::OP_ROT) |=>
        {acc, carry_flag} == {$past(carry_flag), $past(acc)}) else $error("Rotate wrong");
    a_carry_untouched:
    assert property (run && instr_word != cio_pkg::OP_ROT |=> $stable(carry_flag))
        else $error("Carry changed by non-rotate");
    a_keep_backup:
    assert property (s_arm_then(cio_pkg::OP_PD_KEEP) |=> backup && detector_on && !clock_halt)
        else $error("Keep-detector backup wrong");
    a_full_backup:
    assert property (s_arm_then(cio_pkg::OP_PD_FULL) |=> backup && !detector_on && clock_halt)
        else $error("Full-stop backup wrong");
endmodule

bind cio_core cio_core_sva i_sva (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
    .instr_valid(instr_valid), .instr_word(instr_word), .mem_rdata(mem_rdata), .acc(acc),
    .carry_flag(carry_flag), .pin_out(pin_out), .backup(backup), .detector_on(detector_on),
    .clock_halt(clock_halt));

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0;
    logic wake = 1'b0;
    logic ce = 1'b1;
    logic [9:0] instr_word = 10'h000;
    logic [3:0] mem_rdata = 4'h0;
    logic [12:0] level = 13'h0000;
    cio_pkg::cio_port_s pin_in, pin_out, pv;
    cio_pkg::cio_port_s m_out = '0;
    logic [3:0] acc, ptr_x, ptr_y, mem_wdata;
    logic carry_flag, mem_we, skipped, backup, detector_on, clock_halt;
    logic [9:0] w;
    int errors = 0, check_count = 0, cycles = 0;
    int m_acc = 0, m_cy = 0, m_x = 0, m_y = 0, m_run = 0, op, n, t, sk;
    logic [9:0] ops [15] = '{cio_pkg::OP_IN_K, cio_pkg::OP_IN_P0, cio_pkg::OP_IN_P1,
        cio_pkg::OP_IN_P2, cio_pkg::OP_IN_P3, cio_pkg::OP_OUT_K, cio_pkg::OP_OUT_P0,
        cio_pkg::OP_OUT_P1, cio_pkg::OP_OUT_P2, cio_pkg::OP_OUT_P3, cio_pkg::OP_OR,
        cio_pkg::OP_ROT, cio_pkg::OP_LA_BASE, cio_pkg::OP_RB_BASE, cio_pkg::OP_LXY_BASE};

    always #12.5 clk_sys = ~clk_sys;
    cio_pin_model i_pins (.clk_sys(clk_sys), .level(level), .pin_in(pin_in));
    cio_core i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .instr_valid(instr_valid),
        .instr_word(instr_word), .mem_rdata(mem_rdata), .pin_in(pin_in), .wake(wake), .acc(acc),
        .carry_flag(carry_flag), .ptr_x(ptr_x), .ptr_y(ptr_y), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .pin_out(pin_out), .skipped(skipped), .backup(backup),
        .detector_on(detector_on), .clock_halt(clock_halt));
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Valid stays high between back-to-back words; only idle lowers it
    task automatic issue(input logic [9:0] word);
        instr_word = word;
        instr_valid = 1'b1;
        @(negedge clk_sys);
    endtask
    task automatic pwr(input logic [9:0] pd, input logic armed, input logic full);
        if (armed) issue(cio_pkg::OP_PD_ARM);
        issue(pd);
        chk("backup", 13'(armed), 13'(backup));
        chk("detector", 13'(!(armed && full)), 13'(detector_on));
        chk("halt", 13'(armed && full), 13'(clock_halt));
        issue(cio_pkg::OP_LA_BASE | 10'h005);
        if (!armed) m_acc = 5;
        chk("acc held", 13'(m_acc), 13'(acc));
        instr_valid = 1'b0;
        wake = 1'b1;
        repeat (2) @(negedge clk_sys);
        wake = 1'b0;
        @(negedge clk_sys);
        chk("awake", 13'h0000, 13'(backup));
        // Clock enable low: a presented load must change nothing
        ce = 1'b0;
        issue(cio_pkg::OP_LA_BASE | 10'(~m_acc & 15));
        chk("frozen acc", 13'(m_acc), 13'(acc));
        ce = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        void'($urandom(30));
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("reset acc", 13'h0000, 13'(acc));
        chk("reset detector", 13'h0001, 13'(detector_on));
        for (int it = 0; it < 200; it++) begin
            level = 13'($urandom);
            pv = level;
            instr_valid = 1'b0;
            // Pins pass the model flop and two synchroniser stages first
            repeat (4) @(negedge clk_sys);
            for (int b = 0; b < 3; b++) begin
                op = $urandom_range(14);
                n = $urandom_range(255);
                mem_rdata = 4'($urandom);
                t = op == 12 ? n % 16 : op == 13 ? n % 4 : op == 14 ? n : 0;
                w = ops[op] | 10'(t);
                sk = (op == 12 && m_run == 1) || (op == 14 && m_run == 2);
                case (op)
                    0: m_acc = pv.k;
                    1: m_acc = pv.p0;
                    2: m_acc = pv.p1;
                    3: m_acc = pv.p2;
                    4: m_acc = pv.p3;
                    5: m_out.k = m_acc[0];
                    6: m_out.p0 = 4'(m_acc);
                    7: m_out.p1 = 4'(m_acc);
                    8: m_out.p2 = 2'(m_acc);
                    9: m_out.p3 = 2'(m_acc);
                    10: m_acc = m_acc | mem_rdata;
                    11: begin
                        t = m_cy;
                        m_cy = m_acc % 2;
                        m_acc = m_acc / 2 + t * 8;
                    end
                    12: if (!sk) m_acc = n % 16;
                    13: begin
                        t = mem_rdata;
                        t[n % 4] = 1'b0;
                    end
                    14: if (!sk) begin
                        m_x = n / 16;
                        m_y = n % 16;
                    end
                    default: ;
                endcase
                m_run = op == 12 ? 1 : op == 14 ? 2 : 0;
                issue(w);
                chk("acc", 13'(m_acc), 13'(acc));
                chk("carry", 13'(m_cy), 13'(carry_flag));
                chk("pointers", 13'(m_x * 16 + m_y), 13'({ptr_x, ptr_y}));
                chk("pins", 13'(m_out), 13'(pin_out));
                chk("skipped", 13'(sk), 13'(skipped));
                chk("mem we", 13'(op == 13), 13'(mem_we));
                if (op == 13) chk("mem data", 13'(t), 13'(mem_wdata));
            end
        end
        pwr(cio_pkg::OP_PD_KEEP, 1'b1, 1'b0);
        pwr(cio_pkg::OP_PD_FULL, 1'b1, 1'b1);
        pwr(cio_pkg::OP_PD_KEEP, 1'b0, 1'b0);
        pwr(cio_pkg::OP_PD_FULL, 1'b0, 1'b1);
        summarize();
    end
endmodule
